// >>> hdl/dbta_pkg.sv
// Overview of operation
// - Busy output goes active the cycle after a qualified grant is recognised.
// - Qualified retry together with grant on overlapped tenure keeps busy inactive.
// - Retry of a new address still lets earlier queued tenures take the bus.
// - Snoop response window may start two cycles after transfer start.
// - Beat acked the cycle before the window is discarded on retry; tenure aborted.
// - Beat acked in the window's first cycle is discarded on retry; tenure aborted.
// - Retry before grant cancels the pending tenure; system must not grant it.
// - Retry during a transfer ends it after the first retry cycle, cutting bursts.
// - Retry in the grant cycle disqualifies it; the next qualified grant is served.
// - In streaming mode busy is output only and never sampled.
// - Outside streaming, own busy observed; one idle cycle before the next grant.
// - Up to three data tenures are queued and served on qualified grants.
// - Without a reorder request tenures run in address order.
// - Write-first with a qualified grant runs the oldest pending write first.
// - A qualified grant is always taken; write-first without writes runs a read.
// - Busy is released on final termination in every mode, streaming included.
package dbta_pkg;

  localparam int TT_W = 5;
  // transfer type bit that is clear for address-only operations
  localparam int TT_DATA_BIT = 3;
  // transfer type bit that is set for reads
  localparam int TT_READ_BIT = 1;

  localparam int QUEUE_DEPTH = 3;
  localparam int QIDX_W = 2;
  localparam int BEAT_W = 3;
  localparam logic [BEAT_W-1:0] BEATS_SINGLE = 3'h1;
  localparam logic [BEAT_W-1:0] BEATS_BURST = 3'h4;

  localparam int SNOOP_W = 4;
  localparam logic [SNOOP_W-1:0] SNOOP_FIRST = 4'h2;
  localparam logic [SNOOP_W-1:0] SNOOP_MAX = 4'hF;
  localparam logic [SNOOP_W-1:0] ONE_CYCLE = 4'h1;

  typedef struct packed {
    logic wr;
    logic burst;
  } dbta_ten_s;

  typedef struct packed {
    logic start;
    logic [TT_W-1:0] ttype;
    logic burst;
    logic ack;
    logic retry;
  } dbta_addr_s;

  function automatic logic dbta_needs_data(input logic [TT_W-1:0] tt);
    return tt[TT_DATA_BIT];
  endfunction

  function automatic logic dbta_is_write(input logic [TT_W-1:0] tt);
    return ~tt[TT_READ_BIT];
  endfunction

endpackage

// >>> hdl/dbta_queue.sv
`timescale 1ns/1ps
`default_nettype none
module dbta_queue import dbta_pkg::*; #(
  parameter int DEPTH = QUEUE_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic push_i,
  input wire dbta_ten_s push_ent_i,
  input wire logic drop_i,
  // drain side
  input wire logic pop_i,
  input wire logic write_first_i,
  output logic [QIDX_W-1:0] sel_idx_o,
  output dbta_ten_s sel_ent_o,
  output logic [QIDX_W:0] count_o
);
  typedef struct packed {
    dbta_ten_s [DEPTH-1:0] ent;
    logic [QIDX_W:0] cnt;
  } dbta_q_s;

  dbta_q_s s;
  dbta_q_s next_s;
  logic [QIDX_W-1:0] sel;

  always_comb begin
    sel = '0;
    if (write_first_i) begin
      for (int i = DEPTH - 1; i >= 0; i--) begin
        if (QIDX_W'(i) < s.cnt[QIDX_W-1:0] || s.cnt == (QIDX_W + 1)'(DEPTH)) begin
          if (s.ent[i].wr) begin
            sel = QIDX_W'(i);
          end
        end
      end
    end
    // no write queued leaves sel at the oldest entry
  end

  assign sel_idx_o = sel;
  assign sel_ent_o = s.ent[sel];
  assign count_o = s.cnt;

  always_comb begin
    next_s = s;
    if (pop_i && s.cnt != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        if (QIDX_W'(i) >= sel) begin
          next_s.ent[i] = s.ent[i + 1];
        end
      end
      next_s.cnt = s.cnt - 1'b1;
    end else if (drop_i && s.cnt != '0) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    if (push_i && next_s.cnt != (QIDX_W + 1)'(DEPTH)) begin
      next_s.ent[next_s.cnt[QIDX_W-1:0]] = push_ent_i;
      next_s.cnt = next_s.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/dbta_snoop.sv
`timescale 1ns/1ps
`default_nettype none
module dbta_snoop import dbta_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // address tenure
  input wire logic start_i,
  input wire logic ack_i,
  // retry window
  output logic open_o,
  output logic [SNOOP_W-1:0] cnt_o
);
  typedef struct packed {
    logic open;
    logic acked;
    logic [SNOOP_W-1:0] cnt;
  } dbta_sn_s;

  dbta_sn_s s;
  dbta_sn_s next_s;

  assign open_o = s.open;
  assign cnt_o = s.cnt;

  always_comb begin
    next_s = s;
    if (s.cnt != SNOOP_MAX) begin
      next_s.cnt = s.cnt + ONE_CYCLE;
    end
    // the address stays retryable through the cycle after acknowledge
    if (s.acked) begin
      next_s.open = 1'b0;
      next_s.acked = 1'b0;
    end else if (s.open && ack_i) begin
      next_s.acked = 1'b1;
    end
    if (start_i) begin
      next_s.open = 1'b1;
      next_s.acked = 1'b0;
      next_s.cnt = ONE_CYCLE;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/dbta_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module dbta_arbiter import dbta_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // address tenure observed
  input wire dbta_addr_s addr_i,
  // data arbitration
  input wire logic bus_grant_in_i,
  input wire logic write_first_hint_i,
  input wire logic tenure_busy_i,
  output logic tenure_busy_o,
  output logic tenure_busy_oe_o,
  // data termination
  input wire logic transfer_acknowledge_i,
  // modes
  input wire logic streaming_mode_i,
  input wire logic fast_cache_mode_i,
  // status toward the core
  output logic grant_taken_o,
  output logic tenure_active_o,
  output logic tenure_write_o,
  output logic beat_o,
  output logic beat_discard_o,
  output logic tenure_done_o,
  output logic tenure_abort_o,
  output logic ack_too_early_o,
  output logic [QIDX_W:0] queue_count_o
);
  typedef struct packed {
    logic busy;
    logic active;
    logic cur_wr;
    logic [BEAT_W-1:0] beats_left;
    logic cur_open;
    logic open_queued;
    logic beat_pend;
    logic holdoff;
    logic grant_taken;
    logic beat;
    logic discard;
    logic done;
    logic abort;
    logic too_early;
    logic [QIDX_W:0] qcount;
  } dbta_st_s;

  dbta_st_s s;
  dbta_st_s next_s;

  logic snoop_open;
  logic [SNOOP_W-1:0] snoop_cnt;
  logic [QIDX_W-1:0] sel_idx;
  dbta_ten_s sel_ent;
  logic [QIDX_W:0] q_count;
  logic push;
  dbta_ten_s push_ent;
  logic pop;
  logic drop;
  logic retry_q;
  logic busy_seen;
  logic grant_q;
  logic [SNOOP_W-1:0] earliest;

  // earliest legal acknowledge relative to the transfer start
  function automatic logic [SNOOP_W-1:0] ack_earliest(input logic fast, input logic strm);
    if (fast || strm) begin
      return SNOOP_FIRST;
    end
    return SNOOP_FIRST - ONE_CYCLE;
  endfunction

  dbta_snoop u_snoop (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(push),
    .ack_i(addr_i.ack),
    .open_o(snoop_open),
    .cnt_o(snoop_cnt)
  );

  dbta_queue #(.DEPTH(QUEUE_DEPTH)) u_queue (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .push_i(push),
    .push_ent_i(push_ent),
    .drop_i(drop),
    .pop_i(pop),
    .write_first_i(write_first_hint_i),
    .sel_idx_o(sel_idx),
    .sel_ent_o(sel_ent),
    .count_o(q_count)
  );

  // address-only transfers never reach the queue
  assign push = addr_i.start && dbta_needs_data(addr_i.ttype);
  assign push_ent = '{wr: dbta_is_write(addr_i.ttype), burst: addr_i.burst};

  // retry is meaningful from the second cycle after start
  assign retry_q = addr_i.retry && snoop_open && snoop_cnt >= SNOOP_FIRST;

  // streaming mode never looks at the shared busy line
  assign busy_seen = !streaming_mode_i && (tenure_busy_i || s.busy);

  assign grant_q = bus_grant_in_i && !busy_seen && !retry_q && q_count != '0
                   && !s.active && !s.holdoff;

  assign pop = grant_q;
  // only the newest, still retryable, ungranted entry is cancelled
  assign drop = retry_q && s.open_queued && !(s.active && s.cur_open);
  assign earliest = ack_earliest(fast_cache_mode_i, streaming_mode_i);

  always_comb begin
    next_s = s;
    next_s.grant_taken = 1'b0;
    next_s.beat = 1'b0;
    next_s.discard = 1'b0;
    next_s.done = 1'b0;
    next_s.abort = 1'b0;
    next_s.too_early = 1'b0;
    next_s.holdoff = 1'b0;
    if (!snoop_open) begin
      // window passed without retry: buffered beat is final
      next_s.cur_open = 1'b0;
      next_s.open_queued = 1'b0;
      next_s.beat_pend = 1'b0;
    end
    if (drop) begin
      next_s.open_queued = 1'b0;
    end
    if (push) begin
      next_s.open_queued = 1'b1;
    end
    if (grant_q) begin
      next_s.busy = 1'b1;
      next_s.active = 1'b1;
      next_s.grant_taken = 1'b1;
      next_s.cur_wr = sel_ent.wr;
      next_s.beats_left = sel_ent.burst ? BEATS_BURST : BEATS_SINGLE;
      next_s.beat_pend = 1'b0;
      // granted entry is the newest one still inside its snoop window
      if (s.open_queued && snoop_open && !push
          && {1'b0, sel_idx} == q_count - 1'b1) begin
        next_s.cur_open = 1'b1;
        next_s.open_queued = 1'b0;
      end else begin
        next_s.cur_open = 1'b0;
      end
    end else if (s.active && s.cur_open && retry_q) begin
      // abort at once; any provisional or coincident beat is dropped
      next_s.active = 1'b0;
      next_s.busy = 1'b0;
      next_s.abort = 1'b1;
      next_s.discard = s.beat_pend || transfer_acknowledge_i;
      next_s.beat_pend = 1'b0;
      next_s.cur_open = 1'b0;
      next_s.holdoff = !streaming_mode_i;
    end else if (s.active && transfer_acknowledge_i) begin
      next_s.beat = 1'b1;
      if (s.cur_open) begin
        next_s.beat_pend = 1'b1;
        next_s.too_early = snoop_cnt < earliest;
      end
      next_s.beats_left = s.beats_left - 1'b1;
      if (s.beats_left == BEATS_SINGLE) begin
        next_s.active = 1'b0;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.holdoff = !streaming_mode_i;
      end
    end
    next_s.qcount = q_count;
    if (push || pop || drop) begin
      next_s.qcount = next_s.qcount;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tenure_busy_o = s.busy;
  assign tenure_busy_oe_o = s.busy;
  assign grant_taken_o = s.grant_taken;
  assign tenure_active_o = s.active;
  assign tenure_write_o = s.cur_wr;
  assign beat_o = s.beat;
  assign beat_discard_o = s.discard;
  assign tenure_done_o = s.done;
  assign tenure_abort_o = s.abort;
  assign ack_too_early_o = s.too_early;
  assign queue_count_o = s.qcount;
endmodule
`default_nettype wire

// >>> sim/dbta_partner.sv
`timescale 1ns/1ps
`default_nettype none
module dbta_partner (
  // bench side
  input wire logic ref_clk_i,
  input wire logic req_i,
  input wire logic ta_en_i,
  input wire logic other_i,
  // device side
  input wire logic busy_i,
  input wire logic oe_i,
  output logic grant_o,
  output var logic ta_o,
  output logic line_o
);
  // no busy tracking: grant follows the bench request in every cycle
  assign grant_o = req_i;
  // pull-up keeps a released line inactive; other_i is a second master
  assign line_o = (oe_i & busy_i) | other_i;
  // enable taken on the rising edge so a falling-edge bench change cannot race it
  logic en_q = 1'b0;
  always @(posedge ref_clk_i) begin
    en_q <= ta_en_i;
  end
  initial ta_o = 1'b0;
  // acknowledge trails busy by half a cycle: the first beat lands in the first busy cycle
  always @(negedge ref_clk_i) begin
    ta_o <= busy_i & en_q;
  end
endmodule
`default_nettype wire

// >>> sim/dbta_arbiter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dbta_arbiter_assertions import dbta_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // inputs watched
  input wire dbta_addr_s addr_i,
  input wire logic bus_grant_in_i,
  input wire logic tenure_busy_i,
  input wire logic streaming_mode_i,
  // outputs watched
  input wire logic tenure_busy_o,
  input wire logic grant_taken_o,
  input wire logic tenure_done_o,
  input wire logic tenure_abort_o,
  input wire logic [QIDX_W:0] queue_count_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_busy;
    grant_taken_o |-> tenure_busy_o && $past(bus_grant_in_i);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy missing after grant");
  property p_qual;
    grant_taken_o |-> $past(streaming_mode_i) || !$past(tenure_busy_i);
  endproperty
  a_qual: assert property (p_qual)
    else $error("grant taken while line busy");
  property p_rgrant;
    grant_taken_o |-> !$past(addr_i.retry);
  endproperty
  a_rgrant: assert property (p_rgrant)
    else $error("grant taken with retry");
  property p_release;
    tenure_done_o && !streaming_mode_i |-> !tenure_busy_o;
  endproperty
  a_release: assert property (p_release)
    else $error("busy held at done");
  property p_holdoff;
    grant_taken_o && !streaming_mode_i |-> !$past(tenure_done_o || tenure_abort_o);
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("grant taken in holdoff");
  property p_abort;
    tenure_abort_o |-> !tenure_busy_o && $past(addr_i.retry);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort without retry");
  property p_depth;
    queue_count_o <= QUEUE_DEPTH;
  endproperty
  a_depth: assert property (p_depth)
    else $error("queue overfilled");
  property p_push;
    queue_count_o > $past(queue_count_o) |-> $past(addr_i.start && addr_i.ttype[TT_DATA_BIT], 2);
  endproperty
  a_push: assert property (p_push)
    else $error("queue grew without data start");
endmodule
`default_nettype wire

// >>> sim/tb_dbta_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dbta_arbiter import dbta_pkg::*; ();
  localparam logic [TT_W-1:0] WR = 5'h08;
  localparam logic [TT_W-1:0] RD = 5'h0A;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  dbta_addr_s addr_i = '0;
  logic write_first_hint_i = 1'b0;
  logic streaming_mode_i = 1'b0;
  logic fast_cache_mode_i = 1'b0;
  logic act, beat, early;
  logic req = 1'b0;
  logic ta_en = 1'b0;
  logic oth = 1'b0;
  logic bus_grant_in_i, tenure_busy_i, transfer_acknowledge_i, tenure_busy_oe_o;
  logic busy, taken, wr, done, abrt, disc;
  logic [QIDX_W:0] cnt;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  dbta_arbiter u_dut (
    .ref_clk_i,
    .sys_rst_i,
    .addr_i,
    .bus_grant_in_i,
    .write_first_hint_i,
    .tenure_busy_i,
    .tenure_busy_o(busy),
    .tenure_busy_oe_o,
    .transfer_acknowledge_i,
    .streaming_mode_i,
    .fast_cache_mode_i,
    .grant_taken_o(taken),
    .tenure_active_o(act),
    .tenure_write_o(wr),
    .beat_o(beat),
    .beat_discard_o(disc),
    .tenure_done_o(done),
    .tenure_abort_o(abrt),
    .ack_too_early_o(early),
    .queue_count_o(cnt)
  );
  dbta_partner u_far (
    .ref_clk_i,
    .req_i(req),
    .ta_en_i(ta_en),
    .other_i(oth),
    .busy_i(busy),
    .oe_i(tenure_busy_oe_o),
    .grant_o(bus_grant_in_i),
    .ta_o(transfer_acknowledge_i),
    .line_o(tenure_busy_i)
  );
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // start then acknowledge next cycle, so the retry window is one cycle
  task automatic issue(input logic [TT_W-1:0] tt, input logic b);
    addr_i.start = 1'b1;
    addr_i.ttype = tt;
    addr_i.burst = b;
    step(1);
    addr_i.start = 1'b0;
    addr_i.ack = 1'b1;
    step(1);
    addr_i.ack = 1'b0;
  endtask
  task automatic grant(input logic w);
    req = 1'b1;
    write_first_hint_i = w;
    step(1);
    req = 1'b0;
    write_first_hint_i = 1'b0;
  endtask
  task automatic t_single();
    issue(WR, 1'b0);
    issue(WR, 1'b0);
    ta_en = 1'b1;
    grant(1'b0);
    chk({busy, taken, wr}, 3'h7);
    step(1);
    chk({busy, done, taken}, 3'h2);
    // grant held through the holdoff cycle and into the first accepted one
    req = 1'b1;
    step(1);
    chk({busy, taken, cnt[0]}, 3'h1);
    step(1);
    req = 1'b0;
    chk({busy, taken, wr}, 3'h7);
    step(4);
    $display("single done");
  endtask
  task automatic t_order();
    issue(RD, 1'b0);
    issue(WR, 1'b1);
    issue(RD, 1'b0);
    issue(WR, 1'b0);
    step(1);
    chk(cnt, 3'h3);
    grant(1'b1);
    chk({taken, wr, 1'b0}, 3'h6);
    // four burst beats, then the holdoff cycle
    step(5);
    grant(1'b0);
    chk({taken, wr, 1'b0}, 3'h4);
    step(3);
    grant(1'b1);
    chk({taken, wr, 1'b0}, 3'h4);
    step(3);
    chk(cnt, 3'h0);
    $display("order done");
  endtask
  task automatic t_retry();
    issue(5'h00, 1'b0);
    step(2);
    chk(cnt, 3'h0);
    grant(1'b0);
    chk({busy, taken, 1'b0}, 3'h0);
    issue(WR, 1'b0);
    addr_i.retry = 1'b1;
    step(1);
    addr_i.retry = 1'b0;
    step(2);
    chk(cnt, 3'h0);
    ta_en = 1'b0;
    issue(RD, 1'b0);
    issue(WR, 1'b0);
    addr_i.retry = 1'b1;
    req = 1'b1;
    write_first_hint_i = 1'b1;
    step(1);
    addr_i.retry = 1'b0;
    chk({busy, taken, 1'b0}, 3'h0);
    step(1);
    req = 1'b0;
    write_first_hint_i = 1'b0;
    chk({busy, taken, wr}, 3'h6);
    ta_en = 1'b1;
    step(4);
    $display("retry done");
  endtask
  // grant inside the window so the beat meets the retry
  task automatic t_abort();
    addr_i.start = 1'b1;
    addr_i.ttype = WR;
    addr_i.burst = 1'b1;
    step(1);
    addr_i.start = 1'b0;
    addr_i.ack = 1'b1;
    req = 1'b1;
    step(1);
    addr_i.ack = 1'b0;
    req = 1'b0;
    addr_i.retry = 1'b1;
    step(1);
    addr_i.retry = 1'b0;
    chk({busy, abrt, disc}, 3'h3);
    step(3);
    $display("abort done");
  endtask
  // beat taken in the first window cycle, then retry after it: the held beat is thrown away
  task automatic t_fast();
    fast_cache_mode_i = 1'b1;
    addr_i.start = 1'b1;
    addr_i.ttype = WR;
    addr_i.burst = 1'b1;
    step(1);
    addr_i.start = 1'b0;
    req = 1'b1;
    step(1);
    req = 1'b0;
    addr_i.ack = 1'b1;
    ta_en = 1'b0;
    step(1);
    addr_i.ack = 1'b0;
    addr_i.retry = 1'b1;
    chk({beat, early, act}, 3'h5);
    step(1);
    addr_i.retry = 1'b0;
    chk({busy, abrt, disc}, 3'h3);
    ta_en = 1'b1;
    fast_cache_mode_i = 1'b0;
    step(3);
    $display("fast done");
  endtask
  task automatic t_stream();
    issue(WR, 1'b0);
    oth = 1'b1;
    req = 1'b1;
    step(1);
    chk({busy, taken, 1'b0}, 3'h0);
    streaming_mode_i = 1'b1;
    step(1);
    req = 1'b0;
    chk({busy, taken, 1'b0}, 3'h6);
    step(4);
    streaming_mode_i = 1'b0;
    oth = 1'b0;
    $display("stream done");
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    step(20);
    sys_rst_i = 1'b0;
    step(2);
    t_single();
    t_order();
    t_retry();
    t_abort();
    t_fast();
    t_stream();
    conclude();
  end
endmodule
bind dbta_arbiter dbta_arbiter_assertions u_chk (
  .ref_clk_i,
  .sys_rst_i,
  .addr_i,
  .bus_grant_in_i,
  .tenure_busy_i,
  .streaming_mode_i,
  .tenure_busy_o,
  .grant_taken_o,
  .tenure_done_o,
  .tenure_abort_o,
  .queue_count_o
);
`default_nettype wire
